// ===== hw/lbfs_status_one.sv
// Function
// - string 1 on-voltage in top byte
// - string 2 on-voltage in second byte
// - direct or serial dimming: sample continuously while on
// - internal dimming: sample just before on-phase ends
// - short flag sets with min-on flag, low voltage
// - short flag holds channel off until cleared
// - limp-home auto-clears channel 1 short, min-on
// - filtered overheat sets flag, latches channel 1 off
// - overheat clear accepted only when cooled
// - limp-home retries overheat each retry period
// - live warning bits with hysteresis
// - min-on flag after more than 32 short cycles
// - min-on flag holds channel off until cleared
// - bit 0 carries odd parity
// - word at address 0x05, resets to zero except parity bit 0, which reads 1
// - watchdog failure enters limp-home, flag latched
`timescale 1ns/1ps
`default_nettype none

module lbfs_status_one #(
	parameter int unsigned P_RETRY_CYCLES = lbfs_pkg::RETRY_PERIOD_CYCLES
) (
	input  wire logic                         i_ref_clk,
	input  wire logic                         i_rst,
	// register access from the serial frame logic
	input  wire logic                         i_acc_valid,
	input  wire logic [lbfs_pkg::ADDR_W-1:0]  i_acc_addr,
	input  wire logic                         i_acc_clear,
	output logic                              o_acc_hit,
	output logic [lbfs_pkg::WORD_W-1:0]       o_acc_data,
	// converter and dimming, same clock
	input  wire logic [lbfs_pkg::VOLT_W-1:0]  i_adc1_data,
	input  wire logic [lbfs_pkg::VOLT_W-1:0]  i_adc2_data,
	input  wire logic [1:0]                   i_adc_valid,
	input  wire logic [1:0]                   i_ch_on,
	input  wire logic [1:0]                   i_dim_internal,
	input  wire logic [1:0]                   i_dim_on_end,
	input  wire logic [1:0]                   i_short_ontime,
	input  wire logic                         i_watchdog_failure_flag,
	input  wire logic                         i_wd_flag_clear,
	// analog comparators, asynchronous
	input  wire logic [1:0]                   i_vled_avg_low,
	input  wire logic                         i_tj_over_shutdown,
	input  wire logic                         i_tj_below_restart,
	input  wire logic                         i_tj_over_warn_high,
	input  wire logic                         i_tj_below_warn_high_hys,
	input  wire logic                         i_tj_over_warn_low,
	input  wire logic                         i_tj_below_warn_low_hys,
	// results
	output logic [1:0]                        o_ch_enable,
	output logic                              o_limp_home_mode,
	output logic                              o_watchdog_failure_flag
);
	import lbfs_pkg::*;

	// ------------------------------------------------------------
	// sizes and synchroniser bit positions
	// ------------------------------------------------------------
	localparam int unsigned FILT_W  = $clog2(OVERHEAT_FILTER_CYCLES + 1);
	localparam int unsigned RETRY_W = $clog2(P_RETRY_CYCLES + 1);
	localparam int unsigned CNT_W   = $clog2(MINON_LIMIT + 2);
	localparam int unsigned SY_AVG1 = 0;  // string 1 average below 1.5 v
	localparam int unsigned SY_AVG2 = 1;  // string 2 average below 1.5 v
	localparam int unsigned SY_TSD  = 2;  // at or above shutdown_temperature
	localparam int unsigned SY_COOL = 3;  // below shutdown minus hysteresis
	localparam int unsigned SY_TW2  = 4;  // at or above high warning
	localparam int unsigned SY_TW2C = 5;  // below high warning minus hysteresis
	localparam int unsigned SY_TW1  = 6;  // at or above low warning
	localparam int unsigned SY_TW1C = 7;  // below low warning minus hysteresis

	// ------------------------------------------------------------
	// state of the block, apart from the short on-time counters
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]              sync1;     // first synchroniser stage
		logic [7:0]              sync2;     // second synchroniser stage
		logic [VOLT_W-1:0]       volt1;     // string1_on_voltage
		logic [VOLT_W-1:0]       volt2;     // string2_on_voltage
		logic [1:0]              short_f;   // short flags, ch2..ch1
		logic [1:0]              minon_f;   // short on-time flags
		logic                    ovt;       // overheat_flag_ch1
		logic                    warn_hi;   // heat_warn_high_ch1
		logic                    warn_lo;   // heat_warn_low_ch1
		logic                    limp;      // limp_home_mode
		logic                    wd_flag;   // watchdog_failure_flag
		logic [FILT_W-1:0]       filt_cnt;  // overheat persistence
		logic [RETRY_W-1:0]      retry_cnt; // auto-restart timer
		logic [WORD_W-1:0]       acc_data;  // word returned to host
		logic                    acc_hit;   // answer strobe
	} lbfs_state_s;

	lbfs_state_s state_reg;   // registered state
	lbfs_state_s state_next;  // next state

	logic [WORD_W-1:0] word;       // live status word with parity
	logic              rd_clear;   // read-and-clear of this word
	logic [1:0]        take;       // voltage sample strobes
	logic [1:0]        reach;      // short-cycle count passed limit
	logic [1:0]        cnt_clear;  // short-cycle counter clear
	logic              ovt_set;    // filtered overheat event
	logic              retry_tick; // auto-restart period elapsed
	logic              cool;       // synchronised cooled level

	// ------------------------------------------------------------
	// live word and decode
	// ------------------------------------------------------------
	always_comb begin
		word = FAULT_STATUS_ONE_RESET;
		word[VOLT1_LSB +: VOLT_W] = state_reg.volt1;
		word[VOLT2_LSB +: VOLT_W] = state_reg.volt2;
		word[SHORT1_BIT]          = state_reg.short_f[0];
		word[SHORT2_BIT]          = state_reg.short_f[1];
		word[OVERHEAT_FLAG_CH1_BIT]            = state_reg.ovt;
		word[WARN_HIGH_BIT]       = state_reg.warn_hi;
		word[WARN_LOW_BIT]        = state_reg.warn_lo;
		word[MINON1_BIT]          = state_reg.minon_f[0];
		word[MINON2_BIT]          = state_reg.minon_f[1];
		word[PARITY_BIT]          = ~(^word[WORD_W-1:1]);
	end

	assign rd_clear = i_acc_valid && i_acc_clear && (i_acc_addr == FAULT_STATUS_ONE_ADDR);
	assign cool     = state_reg.sync2[SY_COOL];

	// sample strobe per channel
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			take[c] = i_ch_on[c] && (i_dim_internal[c] ? i_dim_on_end[c]
				: i_adc_valid[c]);
		end
	end

	// overheat persistence and retry period
	assign ovt_set    = state_reg.sync2[SY_TSD] &&
		(state_reg.filt_cnt == FILT_W'(OVERHEAT_FILTER_CYCLES));
	assign retry_tick = state_reg.limp &&
		(state_reg.retry_cnt == RETRY_W'(P_RETRY_CYCLES - 1));

	// ------------------------------------------------------------
	// short on-time counters, one per channel
	// ------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_minon
		lbfs_event_count #(
			.LIMIT (MINON_LIMIT),
			.CNT_W (CNT_W)
		) u_count (
			.i_ref_clk (i_ref_clk),
			.i_rst     (i_rst),
			.i_event   (i_short_ontime[g]),
			.i_clear   (cnt_clear[g]),
			.o_reach   (reach[g])
		);
	end
	assign cnt_clear = state_reg.minon_f & ~state_next.minon_f;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		state_next       = state_reg;
		state_next.sync1 = {i_tj_below_warn_low_hys, i_tj_over_warn_low,
			i_tj_below_warn_high_hys, i_tj_over_warn_high,
			i_tj_below_restart, i_tj_over_shutdown, i_vled_avg_low};
		state_next.sync2 = state_reg.sync1;

		// voltage samples; read-and-clear loses to a new sample
		if (rd_clear) begin
			state_next.volt1 = '0;
			state_next.volt2 = '0;
		end
		if (take[0]) begin
			state_next.volt1 = i_adc1_data;
		end
		if (take[1]) begin
			state_next.volt2 = i_adc2_data;
		end

		// host clear of latched flags, then auto-clear, then sets
		if (rd_clear) begin
			state_next.short_f = '0;
			state_next.minon_f = '0;
			if (cool) begin
				state_next.ovt = 1'b0;
			end
		end
		if (retry_tick) begin
			state_next.short_f[0] = 1'b0;
			state_next.minon_f[0] = 1'b0;
			if (cool) begin
				state_next.ovt = 1'b0;
			end
		end
		for (int c = 0; c < 2; c++) begin
			if (reach[c]) begin
				state_next.minon_f[c] = 1'b1;
				if (state_reg.sync2[SY_AVG1 + c]) begin
					state_next.short_f[c] = 1'b1;
				end
			end
		end
		if (ovt_set) begin
			state_next.ovt = 1'b1;
		end

		// live warnings with hysteresis
		if (state_reg.sync2[SY_TW2]) begin
			state_next.warn_hi = 1'b1;
		end else if (state_reg.sync2[SY_TW2C]) begin
			state_next.warn_hi = 1'b0;
		end
		if (state_reg.sync2[SY_TW1]) begin
			state_next.warn_lo = 1'b1;
		end else if (state_reg.sync2[SY_TW1C]) begin
			state_next.warn_lo = 1'b0;
		end

		// watchdog failure in active mode enters limp-home
		if (i_wd_flag_clear) begin
			state_next.wd_flag = 1'b0;
		end
		if (i_watchdog_failure_flag && !state_reg.limp) begin
			state_next.limp    = 1'b1;
			state_next.wd_flag = 1'b1;
		end

		// overheat persistence counter, saturating
		if (!state_reg.sync2[SY_TSD]) begin
			state_next.filt_cnt = '0;
		end else if (!ovt_set) begin
			state_next.filt_cnt = state_reg.filt_cnt + FILT_W'(1);
		end

		// auto-restart timer runs only in limp-home
		if (!state_reg.limp || retry_tick) begin
			state_next.retry_cnt = '0;
		end else begin
			state_next.retry_cnt = state_reg.retry_cnt + RETRY_W'(1);
		end

		// answer: the word as it stood when the access was taken
		state_next.acc_hit = i_acc_valid && (i_acc_addr == FAULT_STATUS_ONE_ADDR);
		if (state_next.acc_hit) begin
			state_next.acc_data = word;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_acc_hit  = state_reg.acc_hit;
	assign o_acc_data = state_reg.acc_data;
	assign o_ch_enable[0] = !state_reg.short_f[0] && !state_reg.minon_f[0] && !state_reg.ovt;
	assign o_ch_enable[1] = !state_reg.short_f[1] && !state_reg.minon_f[1];
	assign o_limp_home_mode        = state_reg.limp;
	assign o_watchdog_failure_flag = state_reg.wd_flag;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_clear_taken;
		rd_clear && !take[0] && !reach[0] && !retry_tick;
	endsequence

	sequence s_answer;
		##1 o_acc_hit;
	endsequence

	a_parity_odd: assert property (o_acc_hit |-> (^o_acc_data) == 1'b1)
		else $error("status word parity is not odd");
	a_answer_value: assert property (rd_clear |-> s_answer
		##0 (o_acc_data[WORD_W-1:1] == $past(word[WORD_W-1:1])))
		else $error("answer does not hold the word before clearing");
	a_clear_volt: assert property (s_clear_taken |=> state_reg.volt1 == '0)
		else $error("read-and-clear left string 1 sample");
	a_volt_sample: assert property (take[0] |=> state_reg.volt1 == $past(i_adc1_data))
		else $error("string 1 sample not captured");
	a_minon_set: assert property (reach[1] |=> state_reg.minon_f[1] && !o_ch_enable[1])
		else $error("min-on flag or disable missing");
	a_short_cause: assert property ($rose(state_reg.short_f[0]) |->
		$past(reach[0]) && $past(state_reg.sync2[SY_AVG1]))
		else $error("short flag set without its cause");
	a_short_off: assert property (state_reg.short_f[1] |-> !o_ch_enable[1])
		else $error("channel 2 enabled with short flag");
	a_ovt_filter: assert property ($rose(state_reg.ovt) |->
		$past(state_reg.filt_cnt) == FILT_W'(OVERHEAT_FILTER_CYCLES))
		else $error("overheat flag set before filter time");
	a_ovt_hold: assert property (state_reg.ovt && rd_clear && !cool |=>
		state_reg.ovt ##1 (state_reg.ovt || $past(cool)))
		else $error("overheat cleared while still hot");
	a_retry_cool: assert property (retry_tick && cool && !ovt_set |=> !state_reg.ovt)
		else $error("limp-home retry did not clear overheat");
	a_warn_live: assert property ($rose(state_reg.warn_hi) |-> $past(state_reg.sync2[SY_TW2]))
		else $error("high warning rose without threshold");
	a_limp_enter: assert property (i_watchdog_failure_flag |=> o_limp_home_mode)
		else $error("watchdog failure did not enter limp-home");

endmodule

`default_nettype wire

// ===== hw/lbfs_pkg.sv
package lbfs_pkg;

	// ------------------------------------------------------------
	// serial address and word layout of the first status word
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W                 = 6;          // serial address width
	localparam logic [5:0]  FAULT_STATUS_ONE_ADDR  = 6'h05;      // address of the word
	localparam int unsigned WORD_W                 = 24;         // status word width
	localparam logic [23:0] FAULT_STATUS_ONE_RESET = 24'h00_0000; // reset value of bits 23..1; bit 0 reads 1 after reset
	localparam int unsigned VOLT1_LSB              = 16;         // string 1 sample, 23..16
	localparam int unsigned VOLT2_LSB              = 8;          // string 2 sample, 15..8
	localparam int unsigned VOLT_W                 = 8;          // converter result width
	localparam int unsigned SHORT1_BIT             = 7;          // short_flag_ch1
	localparam int unsigned SHORT2_BIT             = 6;          // short_flag_ch2
	localparam int unsigned OVERHEAT_FLAG_CH1_BIT               = 5;          // overheat_flag_ch1
	localparam int unsigned WARN_HIGH_BIT          = 4;          // heat_warn_high_ch1
	localparam int unsigned WARN_LOW_BIT           = 3;          // heat_warn_low_ch1
	localparam int unsigned MINON1_BIT             = 2;          // short_ontime_flag_ch1
	localparam int unsigned MINON2_BIT             = 1;          // short_ontime_flag_ch2
	localparam int unsigned PARITY_BIT             = 0;          // odd parity

	// ------------------------------------------------------------
	// counts and timing
	// ------------------------------------------------------------
	localparam int unsigned MINON_LIMIT       = 32;     // short cycles tolerated
	localparam int unsigned CLK_PERIOD_PS     = 25000;  // 40 mhz reference clock
	localparam int unsigned OVERHEAT_FILTER_NS = 32000; // overheat_filter_time
	localparam int unsigned RETRY_PERIOD_US   = 50000;  // retry_period
	// least time, rounded up
	localparam int unsigned OVERHEAT_FILTER_CYCLES =
		(OVERHEAT_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// period, rounded down
	localparam int unsigned RETRY_PERIOD_CYCLES =
		int'((64'(RETRY_PERIOD_US) * 64'd1000000) / 64'(CLK_PERIOD_PS));

endpackage

// ===== hw/lbfs_event_count.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// saturating event counter, pulses when count passes the limit
// ------------------------------------------------------------
module lbfs_event_count #(
	parameter int unsigned LIMIT = 32,
	parameter int unsigned CNT_W = 6
) (
	input  wire logic i_ref_clk,
	input  wire logic i_rst,
	input  wire logic i_event,
	input  wire logic i_clear,
	output logic      o_reach
);

	logic [CNT_W-1:0] count_reg;  // events seen since clear
	logic [CNT_W-1:0] count_next;

	// pulse on the event that makes the count exceed the limit
	assign o_reach = i_event && (count_reg == CNT_W'(LIMIT));

	// clear restarts the count; an event in the clear cycle counts once
	always_comb begin
		count_next = count_reg;
		if (i_clear) begin
			count_next = i_event ? CNT_W'(1) : '0;
		end else if (i_event && count_reg <= CNT_W'(LIMIT)) begin
			count_next = count_reg + CNT_W'(1);
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

endmodule

`default_nettype wire

// ===== verification/lbfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// host side of the register access, checks odd parity
// ------------------------------------------------------------
module lbfs_host_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_acc_hit,
	input  wire logic [23:0] i_acc_data,
	output logic             o_acc_valid,
	output logic [5:0]       o_acc_addr,
	output logic             o_acc_clear
);
	// idle bus at time zero
	initial begin
		o_acc_valid = 1'b0;
		o_acc_addr  = 6'h00;
		o_acc_clear = 1'b0;
	end

	// one access: one-cycle strobe, bounded wait for the answer
	task automatic access(input logic [5:0] a, input logic c, output logic [23:0] w,
		output logic hit, output logic par_ok);
		hit = 1'b0;
		w   = 24'h00_0000;
		@(posedge i_ref_clk);
		o_acc_valid <= 1'b1;
		o_acc_addr  <= a;
		o_acc_clear <= c;
		@(posedge i_ref_clk);
		o_acc_valid <= 1'b0;
		o_acc_addr  <= ~a; // released lines do not keep the old value
		o_acc_clear <= ~c;
		for (int k = 0; k < 4 && !hit; k++) begin
			@(posedge i_ref_clk);
			if (i_acc_hit === 1'b1) begin
				hit = 1'b1;
				w   = i_acc_data;
			end
		end
		par_ok = (^w === 1'b1);
	endtask
endmodule

`default_nettype wire

// ===== verification/lbfs_status_one_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// bench for the first status word
// ------------------------------------------------------------
module lbfs_status_one_tb;
	import lbfs_pkg::*;
	logic        clk, rst, valid, clear, hit, watchdog_failure_flag, wd_clr; // clock, reset, strobes
	logic        hot, cool, warn_hi, warn_hi_clr, warn_lo, warn_lo_clr; // comparators
	logic        limp_home_mode, wdf, h, p;                                // mode, hit, parity
	logic [5:0]  addr;                                          // access address
	logic [23:0] data, w;                                       // answer, word read
	logic [7:0]  adc1, adc2, v1, v2;                            // converter data
	logic [1:0]  adc_v, ch_on, dim_int, dim_end, short_on, avg_low, en;
	int          n_fail, checks, seed;                          // counters, seed

	lbfs_status_one #(.P_RETRY_CYCLES(50)) i_lbfs_status_one (
		.i_ref_clk(clk), .i_rst(rst), .i_acc_valid(valid), .i_acc_addr(addr),
		.i_acc_clear(clear), .o_acc_hit(hit), .o_acc_data(data),
		.i_adc1_data(adc1), .i_adc2_data(adc2), .i_adc_valid(adc_v), .i_ch_on(ch_on),
		.i_dim_internal(dim_int), .i_dim_on_end(dim_end), .i_short_ontime(short_on),
		.i_watchdog_failure_flag(watchdog_failure_flag), .i_wd_flag_clear(wd_clr), .i_vled_avg_low(avg_low),
		.i_tj_over_shutdown(hot), .i_tj_below_restart(cool),
		.i_tj_over_warn_high(warn_hi), .i_tj_below_warn_high_hys(warn_hi_clr),
		.i_tj_over_warn_low(warn_lo), .i_tj_below_warn_low_hys(warn_lo_clr),
		.o_ch_enable(en), .o_limp_home_mode(limp_home_mode), .o_watchdog_failure_flag(wdf));

	lbfs_host_model i_lbfs_host_model (
		.i_ref_clk(clk), .i_acc_hit(hit), .i_acc_data(data),
		.o_acc_valid(valid), .o_acc_addr(addr), .o_acc_clear(clear));

	// 40 mhz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// expected word with odd parity in bit 0
	function automatic logic [23:0] exp_word(input logic [7:0] a, input logic [7:0] b,
		input logic [6:0] f);
		return {a, b, f, ~^{a, b, f}};
	endfunction

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// n one-cycle pulses on a chosen strobe pair
	task automatic pulse(input int s, input logic [1:0] m, input int n);
		repeat (n) begin
			@(posedge clk);
			case (s)
				0: adc_v <= m;
				1: dim_end <= m;
				default: short_on <= m;
			endcase
			@(posedge clk);
			{adc_v, dim_end, short_on} <= 6'h00;
		end
	endtask

	// read the word and compare it, a missing answer ends the run
	task automatic rdc(input logic c, input logic [7:0] a, input logic [7:0] b,
		input logic [6:0] f);
		i_lbfs_host_model.access(FAULT_STATUS_ONE_ADDR, c, w, h, p);
		if (h !== 1'b1) begin
			n_fail++;
			results();
		end else begin
			check(24'(p), 24'h00_0001);
			check(w, exp_word(a, b, f));
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{adc1, adc2, adc_v, ch_on, dim_int, dim_end, short_on, avg_low} = '0;
		{watchdog_failure_flag, wd_clr, hot, warn_hi, warn_lo} = 5'h00;
		{cool, warn_hi_clr, warn_lo_clr} = 3'h7;
		{n_fail, checks, seed} = {32'd0, 32'd0, 32'd14134};
		rst = 1'b1;
		tick(5);
		rst <= 1'b0;
		@(posedge clk);
		check(24'(en), 24'h00_0003);
		rdc(1'b0, 8'h00, 8'h00, 7'h00);
		i_lbfs_host_model.access(6'h06, 1'b1, w, h, p);
		check(24'(h), 24'h00_0000);
		$display("test reset done");
		// direct sampling only while on, then read-and-clear
		for (int i = 0; i < 4; i++) begin
			v1 = 8'($random(seed));
			v2 = 8'($random(seed));
			adc1 <= v1;
			adc2 <= v2;
			ch_on <= 2'b11;
			pulse(0, 2'b11, 1);
			ch_on <= 2'b00;
			adc1 <= ~v1;
			adc2 <= ~v2;
			pulse(0, 2'b11, 1);
			rdc(1'b1, v1, v2, 7'h00);
			rdc(1'b0, 8'h00, 8'h00, 7'h00);
		end
		// internal dimming samples only at the on-phase end
		{ch_on, dim_int} <= 4'hF;
		adc1 <= v2;
		adc2 <= v1;
		pulse(1, 2'b11, 1);
		adc1 <= ~v2;
		adc2 <= ~v1;
		pulse(0, 2'b11, 1);
		rdc(1'b1, v2, v1, 7'h00);
		dim_int <= 2'b00;
		$display("test sampling done");
		// short on-time count, short flag with low average
		avg_low <= 2'b01;
		pulse(2, 2'b11, 32);
		tick(4);
		rdc(1'b0, 8'h00, 8'h00, 7'h00);
		pulse(2, 2'b11, 1);
		tick(2);
		check(24'(en), 24'h00_0000);
		rdc(1'b1, 8'h00, 8'h00, 7'h43);
		check(24'(en), 24'h00_0003);
		pulse(2, 2'b10, 32);
		tick(4);
		rdc(1'b0, 8'h00, 8'h00, 7'h00);
		$display("test min on done");
		// live warnings with hysteresis, not cleared by reads
		{warn_hi, warn_lo, warn_hi_clr, warn_lo_clr} <= 4'hC;
		tick(5);
		rdc(1'b1, 8'h00, 8'h00, 7'h0C);
		{warn_hi, warn_lo} <= 2'h0;
		tick(5);
		rdc(1'b0, 8'h00, 8'h00, 7'h0C);
		warn_hi_clr <= 1'b1;
		tick(5);
		rdc(1'b0, 8'h00, 8'h00, 7'h04);
		warn_lo_clr <= 1'b1;
		tick(5);
		rdc(1'b0, 8'h00, 8'h00, 7'h00);
		$display("test warnings done");
		// filtered overheat, clear refused while hot
		{hot, cool} <= 2'b10;
		tick(1200);
		rdc(1'b0, 8'h00, 8'h00, 7'h00);
		tick(100);
		check(24'(en), 24'h00_0002);
		rdc(1'b1, 8'h00, 8'h00, 7'h10);
		rdc(1'b0, 8'h00, 8'h00, 7'h10);
		{hot, cool} <= 2'b01;
		tick(5);
		rdc(1'b1, 8'h00, 8'h00, 7'h10);
		rdc(1'b0, 8'h00, 8'h00, 7'h00);
		check(24'(en), 24'h00_0003);
		$display("test overheat done");
		// watchdog failure, limp-home retries
		check(24'({limp_home_mode, wdf}), 24'h00_0000);
		watchdog_failure_flag <= 1'b1;
		@(posedge clk);
		watchdog_failure_flag <= 1'b0;
		tick(2);
		check(24'({limp_home_mode, wdf}), 24'h00_0003);
		wd_clr <= 1'b1;
		@(posedge clk);
		wd_clr <= 1'b0;
		tick(2);
		check(24'({limp_home_mode, wdf}), 24'h00_0002);
		pulse(2, 2'b11, 33);
		tick(120);
		rdc(1'b0, 8'h00, 8'h00, 7'h01);
		check(24'(en), 24'h00_0001);
		{hot, cool} <= 2'b10;
		tick(1400);
		rdc(1'b0, 8'h00, 8'h00, 7'h11);
		{hot, cool} <= 2'b01;
		tick(120);
		rdc(1'b0, 8'h00, 8'h00, 7'h01);
		check(24'(en), 24'h00_0001);
		$display("test limp home done");
		results();
	end
endmodule

`default_nettype wire
